// *** src/corr_counter.sv ***
// Corrected error counter with a sticky overflow flag.
// Assumes increment and software write come from logic on the same clock.
`timescale 1ns/1ps
module corr_counter
  import ras_err_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             incEn,
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrCount,
  input  wire logic             wrSticky,
  output logic      [WIDTH-1:0] count,
  output logic                  sticky,
  output logic                  ovfPulse
);

  logic [WIDTH-1:0] count_r;
  logic             sticky_r;

  // Overflow is the increment that wraps the full counter
  assign ovfPulse = incEn & (&count_r);
  assign count    = count_r;
  assign sticky   = sticky_r;

  // Count and sticky flag; an overflow beats a software clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r  <= '0;
      sticky_r <= 1'b0;
    end else begin
      if (wrEn) begin
        count_r <= wrCount;
      end else if (incEn) begin
        count_r <= count_r + 1'b1;
      end
      if (ovfPulse) begin
        sticky_r <= 1'b1;
      end else if (wrEn) begin
        sticky_r <= wrSticky;
      end
    end
  end

endmodule // corr_counter

// *** src/locate_mux.sv ***
// Masks the raw way, subbank and bank of a failing RAM by detecting unit.
// Assumes the raw location is valid alongside the unit code.
`timescale 1ns/1ps
module locate_mux
  import ras_err_pkg::*;
(
  input  wire unit_t   unit,
  input  wire locate_t raw,
  output locate_t      masked
);

  // Unit classes that use each field
  wire wayTwoBits   = (unit == UNIT_L1I_TAG) || (unit == UNIT_L1I_DATA) ||
                      (unit == UNIT_OP_CACHE) || (unit == UNIT_L1D_DATA) ||
                      (unit == UNIT_L1D_TAG);
  wire wayThreeBits = (unit == UNIT_L2_TLB) || (unit == UNIT_L2_TAG);
  wire subbankUsed  = (unit == UNIT_L1I_DATA);
  wire bankUsed     = (unit == UNIT_L1I_DATA) || (unit == UNIT_OP_CACHE) ||
                      (unit == UNIT_L2_TAG) || (unit == UNIT_L2_DATA) ||
                      (unit == UNIT_L2_QUEUE) || (unit == UNIT_L2_PORT);

  // Unused bits are held at zero
  assign masked.way     = wayTwoBits   ? {2'h0, raw.way[1:0]} :
                          wayThreeBits ? {1'h0, raw.way[2:0]} : 4'h0;
  assign masked.subbank = subbankUsed & raw.subbank;
  assign masked.bank    = bankUsed ? raw.bank : 2'h0;

endmodule // locate_mux

// *** src/ras_err_pkg.sv ***
// Shared constants and types for the error record register block.
// Assumes a single core clock domain and system register style access.
package ras_err_pkg;

  // ==========================================================================
  // Control register layout
  localparam int            CTL_DETECT_BIT = 0;
  localparam int            CTL_CFI_BIT    = 8;
  localparam logic          CTL_DETECT_RST = 1'b0;
  localparam logic          CTL_CFI_RST    = 1'b0;

  // ==========================================================================
  // Capability register fields, assembled into the constant feature word
  localparam logic [1:0]    TIMESTAMP_SUPPORT      = 2'h0;
  localparam logic [1:0]    CRITICAL_IRQ_SUPPORT   = 2'h0;
  localparam logic [1:0]    FAULT_INSERTION_SUPPORT = 2'h0;
  localparam logic [1:0]    CORRECTED_OVERWRITE    = 2'h0;
  localparam logic [1:0]    DEFERRED_RECOVERY_IRQ  = 2'h0;
  localparam logic          REPEAT_COUNTER_PRESENT = 1'b1;
  localparam logic [2:0]    CORRECTED_COUNT_FEAT   = 3'h2;
  localparam logic [1:0]    CORRECTED_FAULT_IRQ    = 2'h2;
  localparam logic [1:0]    INBAND_UNCORR_REPORT   = 2'h1;
  localparam logic [1:0]    FAULT_IRQ_FEATURE      = 2'h2;
  localparam logic [1:0]    RECOVERY_IRQ_FEATURE   = 2'h2;
  localparam logic [1:0]    POSTPONE_ERRORS_FEAT   = 2'h0;
  localparam logic [1:0]    DETECT_CORRECT_FEAT    = 2'h2;
  localparam logic [63:0]   FEATURE_RESET          = 64'h0000_0000_0000_A9A2;
  localparam logic [63:0]   FEATURE_WORD = {38'h0, TIMESTAMP_SUPPORT, CRITICAL_IRQ_SUPPORT,
    FAULT_INSERTION_SUPPORT, CORRECTED_OVERWRITE, DEFERRED_RECOVERY_IRQ,
    REPEAT_COUNTER_PRESENT, CORRECTED_COUNT_FEAT, CORRECTED_FAULT_IRQ, INBAND_UNCORR_REPORT,
    FAULT_IRQ_FEATURE, RECOVERY_IRQ_FEATURE, POSTPONE_ERRORS_FEAT, DETECT_CORRECT_FEAT};

  // ==========================================================================
  // Syndrome register layout
  localparam int            CNT_W          = 7;
  localparam int            OTHER_OVF_BIT  = 47;
  localparam int            OTHER_CNT_LSB  = 40;
  localparam int            REPEAT_OVF_BIT = 39;
  localparam int            REPEAT_CNT_LSB = 32;
  localparam int            WAY_LSB        = 28;
  localparam int            SUBBANK_BIT    = 25;
  localparam int            BANK_LSB       = 23;
  localparam logic [CNT_W-1:0] COUNT_RST   = 7'h00;
  localparam int            SYND_W         = 8;

  // ==========================================================================
  // Record selection and access
  localparam int            RECSEL_W       = 16;
  localparam logic [15:0]   RECORD_SEL_THIS = 16'h0000;

  typedef enum logic [1:0] {
    REG_CTRL     = 2'b00,
    REG_FEATURE  = 2'b01,
    REG_SYNDROME = 2'b10
  } regId_t;

  typedef enum logic [3:0] {
    UNIT_L1I_TAG   = 4'b0000,
    UNIT_L1I_DATA  = 4'b0001,
    UNIT_OP_CACHE  = 4'b0010,
    UNIT_L1D_DATA  = 4'b0011,
    UNIT_L1D_TAG   = 4'b0100,
    UNIT_L2_TLB    = 4'b0101,
    UNIT_L2_TAG    = 4'b0110,
    UNIT_L2_DATA   = 4'b0111,
    UNIT_L2_QUEUE  = 4'b1000,
    UNIT_L2_PORT   = 4'b1001
  } unit_t;

  typedef struct packed {
    logic [3:0] way;
    logic       subbank;
    logic [1:0] bank;
  } locate_t;

  typedef struct packed {
    logic              valid;
    unit_t             unit;
    logic [SYND_W-1:0] syndrome;
    locate_t           loc;
  } ceEvent_t;

  typedef struct packed {
    logic                rdEn;
    logic                wrEn;
    regId_t              regId;
    logic [RECSEL_W-1:0] recordSel;
    logic [63:0]         wrData;
  } regReq_t;

endpackage

// *** src/ras_error_record_regs.sv ***
// Error record registers: control enables, constant capability word and
// syndrome register with repeat and other corrected error counters.
// Assumes corrected error reports and register accesses arrive on core_clk.
`timescale 1ns/1ps
module ras_error_record_regs
  import ras_err_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  input  wire regReq_t  regReq,
  output logic [63:0]   rdData,
  output logic          rdValid,
  input  wire ceEvent_t ceEvent,
  input  wire logic     recordClear,
  output logic          detectCorrectEnable,
  output logic          faultIrq,
  output logic          statusOverflowSet
);

  // ==========================================================================
  // Access decode
  logic        detectEn_r;
  logic        cfiEn_r;
  logic [63:0] rdData_r;
  logic        rdValid_r;

  // Alias accesses route here only when the selector names this record
  // selector zero routes
  wire selThis  = (regReq.recordSel == RECORD_SEL_THIS);
  wire wrCtrl   = regReq.wrEn & selThis & (regReq.regId == REG_CTRL);
  wire wrSynd   = regReq.wrEn & selThis & (regReq.regId == REG_SYNDROME);
  wire rdAccept = regReq.rdEn & selThis;

  // ==========================================================================
  // Control register
  // detection enable bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      detectEn_r <= CTL_DETECT_RST;
      cfiEn_r    <= CTL_CFI_RST;
    end else if (wrCtrl) begin
      detectEn_r <= regReq.wrData[CTL_DETECT_BIT];
      cfiEn_r    <= regReq.wrData[CTL_CFI_BIT];
    end
  end

  assign detectCorrectEnable = detectEn_r;

  // ==========================================================================
  // Error classification
  logic              recValid_r;
  unit_t             recUnit_r;
  logic [SYND_W-1:0] recSynd_r;
  locate_t           recLoc_r;
  locate_t           maskedLoc;
  locate_t           wrLoc;

  // Events are dropped while detection and correction is off
  // disabled drops events
  wire ceTake   = ceEvent.valid & detectEn_r;
  wire firstErr = ceTake & ~recValid_r;
  wire sameSynd = (ceEvent.unit == recUnit_r) && (ceEvent.syndrome == recSynd_r);
  wire matchErr = ceTake & recValid_r & sameSynd;
  wire otherErr = ceTake & recValid_r & ~sameSynd;
  wire repInc   = firstErr | matchErr;

  // Location field masking per detecting unit
  // way masking by unit
  locate_mux locate_mux_inst (
    .unit   (ceEvent.unit),
    .raw    (ceEvent.loc),
    .masked (maskedLoc)
  );

  // Software view of the location fields
  assign wrLoc.way     = regReq.wrData[WAY_LSB +: 4];
  assign wrLoc.subbank = regReq.wrData[SUBBANK_BIT];
  assign wrLoc.bank    = regReq.wrData[BANK_LSB +: 2];

  // Recorded syndrome; the first error captures it, a clear re-arms it
  // first error captures details
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      recValid_r <= 1'b0;
      recUnit_r  <= UNIT_L1I_TAG;
      recSynd_r  <= '0;
      recLoc_r   <= '0;
    end else begin
      if (firstErr) begin
        recValid_r <= 1'b1;
        recUnit_r  <= ceEvent.unit;
        recSynd_r  <= ceEvent.syndrome;
      end else if (recordClear) begin
        recValid_r <= 1'b0;
      end
      if (firstErr) begin
        recLoc_r <= maskedLoc;
      end else if (wrSynd) begin
        recLoc_r <= wrLoc;
      end
    end
  end

  // ==========================================================================
  // Counters
  logic [CNT_W-1:0] repCount;
  logic [CNT_W-1:0] othCount;
  logic             repSticky;
  logic             othSticky;
  logic             repOvf;
  logic             othOvf;

  corr_counter #(.WIDTH(CNT_W)) uRepeat (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .incEn    (repInc),
    .wrEn     (wrSynd),
    .wrCount  (regReq.wrData[REPEAT_CNT_LSB +: CNT_W]),
    .wrSticky (regReq.wrData[REPEAT_OVF_BIT]),
    .count    (repCount),
    .sticky   (repSticky),
    .ovfPulse (repOvf)
  );

  corr_counter #(.WIDTH(CNT_W)) uOther (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .incEn    (otherErr),
    .wrEn     (wrSynd),
    .wrCount  (regReq.wrData[OTHER_CNT_LSB +: CNT_W]),
    .wrSticky (regReq.wrData[OTHER_OVF_BIT]),
    .count    (othCount),
    .sticky   (othSticky),
    .ovfPulse (othOvf)
  );

  // Counter overflow raises the status flag; record status is kept
  // overflow sets status flag
  assign statusOverflowSet = repOvf | othOvf;

  // Fault interrupt level while enabled and either flag is set
  // fault irq from flags
  assign faultIrq = cfiEn_r & (repSticky | othSticky);

  // ==========================================================================
  // Read path
  wire [63:0] ctrlWord = {55'h0, cfiEn_r, 7'h00, detectEn_r};
  wire [63:0] syndWord = {16'h0000, othSticky, othCount, repSticky, repCount,
                          recLoc_r.way, 2'h0, recLoc_r.subbank, recLoc_r.bank, 23'h0};
  wire [63:0] rdMux = !selThis                      ? 64'h0 :
                      (regReq.regId == REG_CTRL)    ? ctrlWord :
                      (regReq.regId == REG_FEATURE) ? FEATURE_WORD :
                      (regReq.regId == REG_SYNDROME) ? syndWord : 64'h0;

  // Read data is registered; writes to the capability word change nothing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r  <= 64'h0;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regReq.rdEn;
      if (regReq.rdEn) begin
        rdData_r <= rdMux;
      end
    end
  end

  assign rdData  = rdData_r;
  assign rdValid = rdValid_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_feature_constant: assert property (
    rdAccept && regReq.regId == REG_FEATURE |=> rdValid && rdData == FEATURE_RESET)
    else $error("capability word read wrong");

  a_feature_fields: assert property (
    rdAccept && regReq.regId == REG_FEATURE |=> rdData[11:10] == 2'h2 && rdData[7:6] == 2'h2
      && rdData[5:4] == 2'h2 && rdData[9:8] == 2'h1
      && rdData[3:0] == 4'h2 && rdData[25:16] == 10'h000 && rdData[15])
    else $error("capability fields wrong");

  a_disabled_ignore: assert property (
    !detectCorrectEnable && ceEvent.valid && !wrSynd |=> $stable(repCount) && $stable(othCount))
    else $error("error counted while detection disabled");

  a_repeat_count: assert property (
    firstErr && !wrSynd |=> repCount == CNT_W'($past(repCount) + 7'h01) && $stable(othCount))
    else $error("first error did not bump repeat count");

  a_other_count: assert property (
    otherErr && !wrSynd |=> othCount == CNT_W'($past(othCount) + 7'h01) && $stable(repCount))
    else $error("mismatching error did not bump other count");

  a_repeat_sticky: assert property (
    repInc && !wrSynd && repCount == 7'h7F |-> statusOverflowSet ##1 repSticky && repCount == 7'h00)
    else $error("repeat overflow not recorded");

  a_other_sticky: assert property (
    otherErr && !wrSynd && othCount == 7'h7F |=> othSticky && othCount == 7'h00)
    else $error("other overflow not recorded");

  a_fault_irq: assert property (
    $rose(othSticky) && cfiEn_r |-> faultIrq)
    else $error("fault interrupt missing on overflow");

  a_other_record: assert property (
    regReq.rdEn && !selThis |=> rdValid && rdData == 64'h0)
    else $error("other record read returned data");

  a_reserved_zero: assert property (
    rdAccept && regReq.regId == REG_SYNDROME |=> rdData[63:48] == 16'h0 && rdData[27:26] == 2'h0)
    else $error("reserved syndrome bits not zero");

  a_way_unused: assert property (
    firstErr && ceEvent.unit == UNIT_L2_DATA |=> recLoc_r.way == 4'h0)
    else $error("way recorded for unit without way");

  a_detect_on: assert property (
    wrCtrl && regReq.wrData[CTL_DETECT_BIT] |=> detectCorrectEnable)
    else $error("detection enable not stored");

  a_detect_off: assert property (
    wrCtrl && !regReq.wrData[CTL_DETECT_BIT] |=> !detectCorrectEnable)
    else $error("detection disable not stored");

  a_cfi_off: assert property (
    wrCtrl && !regReq.wrData[CTL_CFI_BIT] |=> !faultIrq)
    else $error("fault interrupt not gated off");

  a_foreign_write: assert property (
    regReq.wrEn && !selThis |=> $stable(detectEn_r) && $stable(cfiEn_r))
    else $error("write to other record changed control");

  a_status_other: assert property (
    otherErr && othCount == 7'h7F |-> statusOverflowSet)
    else $error("other wrap did not flag status overflow");

  a_match_repeat: assert property (
    matchErr && !wrSynd |=> repCount == CNT_W'($past(repCount) + 7'h01) && $stable(othCount))
    else $error("matching error did not bump repeat count");

  a_rep_sticky_hold: assert property (
    repSticky && !wrSynd |=> repSticky)
    else $error("repeat overflow flag dropped");

  a_oth_sticky_hold: assert property (
    othSticky && !wrSynd |=> othSticky)
    else $error("other overflow flag dropped");

  a_subbank_unused: assert property (
    firstErr && ceEvent.unit != UNIT_L1I_DATA |=> !recLoc_r.subbank)
    else $error("subbank recorded for unit without subbank");

  a_bank_unused: assert property (
    firstErr && (ceEvent.unit == UNIT_L1I_TAG || ceEvent.unit == UNIT_L1D_DATA
      || ceEvent.unit == UNIT_L1D_TAG || ceEvent.unit == UNIT_L2_TLB) |=> recLoc_r.bank == 2'h0)
    else $error("bank recorded for unit without bank");

  a_feature_absent: assert property (
    rdAccept && regReq.regId == REG_FEATURE |=> rdData[25:16] == 10'h000)
    else $error("absent feature fields not zero");

  a_feature_counter: assert property (
    rdAccept && regReq.regId == REG_FEATURE |=> rdData[14:12] == 3'h2)
    else $error("counter size field wrong");

  a_feature_inband: assert property (
    rdAccept && regReq.regId == REG_FEATURE |=> rdData[9:8] == 2'h1)
    else $error("in band reporting field wrong");

  a_feature_defer: assert property (
    rdAccept && regReq.regId == REG_FEATURE |=> rdData[3:2] == 2'h0)
    else $error("deferral field wrong");

  a_feature_detect: assert property (
    rdAccept && regReq.regId == REG_FEATURE |=> rdData[1:0] == 2'h2)
    else $error("detection control field wrong");

endmodule // ras_error_record_regs

// *** testbench/tb_ras_error_record_regs.sv ***
// Self-checking bench for the error record register block.
// Assumes the design package is compiled first; drives all ports itself.
`timescale 1ns/1ps
module tb_ras_error_record_regs;
  import ras_err_pkg::*;

  // ==========================================================================
  // Clock, reset and design ports
  logic        core_clk;
  logic        rst_n;
  regReq_t     regReq;
  logic [63:0] rdData;
  logic        rdValid;
  ceEvent_t    ceEvent;
  logic        recordClear;
  logic        detectCorrectEnable;
  logic        faultIrq;
  logic        statusOverflowSet;
  logic [63:0] rd;
  logic        ovf;
  int          mismatches;
  int          checks;

  ras_error_record_regs ras_error_record_regs_inst (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .regReq              (regReq),
    .rdData              (rdData),
    .rdValid             (rdValid),
    .ceEvent             (ceEvent),
    .recordClear         (recordClear),
    .detectCorrectEnable (detectCorrectEnable),
    .faultIrq            (faultIrq),
    .statusOverflowSet   (statusOverflowSet)
  );

  // 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Shared helpers
  task automatic step();
    @(posedge core_clk);
    #5;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Syndrome word as laid out in the register
  function automatic logic [63:0] synWord(input logic oo, input logic [6:0] oc,
    input logic ro, input logic [6:0] rc, input logic [3:0] w, input logic s,
    input logic [1:0] b);
    return {16'h0000, oo, oc, ro, rc, w, 2'h0, s, b, 23'h000000};
  endfunction

  task automatic rdReg(input regId_t id, input logic [15:0] sel);
    regReq.rdEn = 1'b1;
    regReq.regId = id;
    regReq.recordSel = sel;
    step();
    chk("rdValid", 64'h1, {63'h0, rdValid});
    rd = rdData;
    regReq.rdEn = 1'b0;
    step();
    chk("rdValid low", 64'h0, {63'h0, rdValid});
  endtask

  task automatic wrReg(input regId_t id, input logic [15:0] sel, input logic [63:0] d);
    regReq.wrEn = 1'b1;
    regReq.regId = id;
    regReq.recordSel = sel;
    regReq.wrData = d;
    step();
    regReq.wrEn = 1'b0;
    step();
  endtask

  task automatic sendEvent(input unit_t u, input logic [7:0] syn, input locate_t loc);
    ceEvent.valid = 1'b1;
    ceEvent.unit = u;
    ceEvent.syndrome = syn;
    ceEvent.loc = loc;
    #10;
    ovf = statusOverflowSet;
    step();
    ceEvent.valid = 1'b0;
    step();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_feature();
    rdReg(REG_FEATURE, 16'h0000);
    chk("feature word", 64'h0000_0000_0000_A9A2, rd);
    wrReg(REG_FEATURE, 16'h0000, 64'hFFFF_FFFF_FFFF_FFFF);
    rdReg(REG_FEATURE, 16'h0000);
    chk("feature after write", 64'h0000_0000_0000_A9A2, rd);
  endtask

  task automatic test_control();
    rdReg(REG_CTRL, 16'h0000);
    chk("ctrl reset", 64'h0, rd);
    sendEvent(UNIT_L1I_DATA, 8'h05, 7'h7F);
    rdReg(REG_SYNDROME, 16'h0000);
    chk("event while disabled", 64'h0, rd);
    wrReg(REG_CTRL, 16'h0000, 64'hFFFF_FFFF_FFFF_FFFF);
    chk("enable out", 64'h1, {63'h0, detectCorrectEnable});
    rdReg(REG_CTRL, 16'h0000);
    chk("ctrl stored bits", 64'h0000_0000_0000_0101, rd);
    wrReg(REG_CTRL, 16'h0001, 64'h0);
    chk("other record write", 64'h1, {63'h0, detectCorrectEnable});
    rdReg(REG_FEATURE, 16'h0001);
    chk("other record read", 64'h0, rd);
  endtask

  task automatic test_counts();
    wrReg(REG_SYNDROME, 16'h0000, 64'h0);
    sendEvent(UNIT_L1I_DATA, 8'h05, 7'h7F);
    chk("no wrap pulse", 64'h0, {63'h0, ovf});
    rdReg(REG_SYNDROME, 16'h0000);
    chk("first capture", synWord(0, 0, 0, 1, 4'h3, 1, 2'h3), rd);
    sendEvent(UNIT_L1I_DATA, 8'h06, 7'h00);
    sendEvent(UNIT_L1I_DATA, 8'h05, 7'h00);
    sendEvent(UNIT_OP_CACHE, 8'h05, 7'h00);
    rdReg(REG_SYNDROME, 16'h0000);
    chk("repeat and other", synWord(0, 2, 0, 2, 4'h3, 1, 2'h3), rd);
  endtask

  task automatic test_overflow();
    wrReg(REG_SYNDROME, 16'h0000, synWord(0, 7'h7F, 0, 7'h7F, 4'h0, 0, 2'h0));
    chk("irq before wrap", 64'h0, {63'h0, faultIrq});
    sendEvent(UNIT_L1I_DATA, 8'h05, 7'h00);
    chk("repeat wrap pulse", 64'h1, {63'h0, ovf});
    chk("irq on repeat wrap", 64'h1, {63'h0, faultIrq});
    sendEvent(UNIT_L1I_DATA, 8'h09, 7'h00);
    chk("other wrap pulse", 64'h1, {63'h0, ovf});
    rdReg(REG_SYNDROME, 16'h0000);
    chk("both sticky", synWord(1, 0, 1, 0, 4'h0, 0, 2'h0), rd);
    sendEvent(UNIT_L1I_DATA, 8'h05, 7'h00);
    rdReg(REG_SYNDROME, 16'h0000);
    chk("sticky holds", synWord(1, 0, 1, 1, 4'h0, 0, 2'h0), rd);
    wrReg(REG_CTRL, 16'h0000, 64'h1);
    chk("irq gated off", 64'h0, {63'h0, faultIrq});
    wrReg(REG_CTRL, 16'h0000, 64'h101);
    chk("irq gated on", 64'h1, {63'h0, faultIrq});
    wrReg(REG_SYNDROME, 16'h0000, 64'h0);
    chk("irq after clear", 64'h0, {63'h0, faultIrq});
  endtask

  task automatic test_locate();
    unit_t       un;
    logic [3:0]  w;
    logic        s;
    logic [1:0]  b;
    for (int u = 0; u < 10; u++) begin
      un = unit_t'(u);
      w = (u < 5) ? 4'h3 : ((un == UNIT_L2_TLB || un == UNIT_L2_TAG) ? 4'h7 : 4'h0);
      s = (un == UNIT_L1I_DATA);
      b = (un == UNIT_L1I_DATA || un == UNIT_OP_CACHE || u > 5) ? 2'h3 : 2'h0;
      recordClear = 1'b1;
      step();
      recordClear = 1'b0;
      step();
      sendEvent(un, 8'h20, 7'h7F);
      rdReg(REG_SYNDROME, 16'h0000);
      chk("location", {32'h0, w, 2'h0, s, b, 23'h0}, {32'h0, rd[31:0]});
      chk("reserved top", 64'h0, {48'h0, rd[63:48]});
    end
  endtask

  // ==========================================================================
  // Verdict and run control
  task automatic test_done();
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 120 cycles the tests need
  initial begin
    #500000;
    mismatches++;
    test_done();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    rst_n = 1'b0;
    regReq = '0;
    ceEvent = '0;
    recordClear = 1'b0;
    repeat (4) @(posedge core_clk);
    #5;
    rst_n = 1'b1;
    step();
    test_feature();
    test_control();
    test_counts();
    test_overflow();
    test_locate();
    test_done();
  end
endmodule // tb_ras_error_record_regs
